// >>> rtl/pfh_pkg.sv
/*
   shared constants, types and bus timing for the parallel flash host controller.
   assumes a single 25 MHz system clock and a flash part on an asynchronous pin bus.
*/
`default_nettype none

package pfh_pkg;

   // bus geometry
   localparam int ADDR_W = 19;        // word address lines
   localparam int DATA_W = 16;        // full data width in word mode
   localparam int BYTE_W = 8;         // low lane width

   // timing, printed figures in ns and derived clock counts
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_ACCESS_NS = 70;   // output gate low to data valid
   localparam int T_WR_PULSE_NS = 45; // write strobe low width
   localparam int SYNC_STAGES = 2;
   localparam int ACC_RAW = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (ACC_RAW < 1) ? 1 : ACC_RAW;
   localparam int WR_RAW = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
   localparam int RD_CYC = ACC_CYC + SYNC_STAGES;   // gate low until synced data is usable

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] RD_LAST = 4'(RD_CYC - 1);
   localparam logic [CNT_W-1:0] WR_LAST = 4'(WR_CYC - 1);
   localparam logic [BYTE_W-1:0] UPPER_ZERO = 8'h00;

   // one user request: byte address in 8-bit mode (bit 0 picks the byte), word address in the low ADDR_W bits in word mode
   typedef struct packed {
      logic isWrite;
      logic [ADDR_W:0] addr;
      logic [DATA_W-1:0] data;
   } pfh_req_s;

   // control strobes and address lines toward the flash
   typedef struct packed {
      logic chipSelN;
      logic outGateN;
      logic wrStrobeN;
      logic [ADDR_W-1:0] addrLines;
   } pfh_bus_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_SETUP,
      ST_RD_WAIT,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_HOLD
   } pfh_state_e;

endpackage

`default_nettype wire

// >>> rtl/pfh_sync2.sv
/*
   two-flop level synchroniser of parameterised width.
   assumes the input may change at any time relative to clk_sys.
*/
`default_nettype none

module pfh_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;

   // first stage feeds only the second stage, to contain metastability
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1_q <= '0;
         syncOut <= '0;
      end else begin
         stage1_q <= asyncIn;
         syncOut <= stage1_q;
      end
   end

endmodule // pfh_sync2

`default_nettype wire

// >>> rtl/pfh_host.sv
/*
   host controller for a parallel boot-block flash: turns user read and command
   write requests into chip select, output gate and write strobe cycles.
   assumes the flash pins are joined outside from the out/oe/in triples and that
   the ready/busy line has its pull-up outside.
*/
`default_nettype none

module pfh_host (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reqValid,
   output logic reqReady,
   input wire pfh_pkg::pfh_req_s req,
   input wire logic byteMode,
   input wire logic flashReset,
   output logic rspValid,
   output logic [pfh_pkg::DATA_W-1:0] rspData,
   output logic busy,
   output pfh_pkg::pfh_bus_s bus,
   output logic wordSel,
   input wire logic [pfh_pkg::BYTE_W-1:0] lowLaneIn,
   output logic [pfh_pkg::BYTE_W-1:0] lowLaneOut,
   output logic lowLaneOe,
   input wire logic [6:0] upperLaneIn,
   output logic [6:0] upperLaneOut,
   output logic upperLaneOe,
   input wire logic topDataIn,
   output logic topDataOut,
   output logic topDataOe,
   input wire logic readyBusyN,
   output logic resetUnprotectN
);

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers

   logic [pfh_pkg::DATA_W-1:0] pinData;
   logic [pfh_pkg::DATA_W-1:0] dataSync;
   logic busySync;

   assign pinData = {topDataIn, upperLaneIn, lowLaneIn};

   pfh_sync2 #(.WIDTH(pfh_pkg::DATA_W)) uDataSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn(pinData),
      .syncOut(dataSync)
   );

   pfh_sync2 #(.WIDTH(1)) uRbSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn(!readyBusyN), // inverted ahead of the flops so reset reads as not busy
      .syncOut(busySync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // request decode

   pfh_pkg::pfh_state_e state_q, state_d;
   logic [pfh_pkg::CNT_W-1:0] cnt_q, cnt_d;
   pfh_pkg::pfh_req_s cur_q, cur_d;
   logic modeByte_q, modeByte_d;
   logic take;
   logic rdDone;
   logic [pfh_pkg::ADDR_W-1:0] addrSel;
   logic [pfh_pkg::DATA_W-1:0] rdWord;

   // width is latched per request so it never changes mid-cycle
   assign take = reqValid && reqReady;
   assign addrSel = modeByte_d ? cur_d.addr[pfh_pkg::ADDR_W:1] :
                                 cur_d.addr[pfh_pkg::ADDR_W-1:0];
   assign rdDone = (state_q == pfh_pkg::ST_RD_WAIT) && (cnt_q == pfh_pkg::RD_LAST);
   // in byte mode the upper bits carry nothing, so they are forced to zero
   assign rdWord = modeByte_q ? {pfh_pkg::UPPER_ZERO, dataSync[pfh_pkg::BYTE_W-1:0]} :
                                dataSync;

   ////////////////////////////////////////////////////////////////////////////
   // bus sequencer: next state

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + pfh_pkg::CNT_ONE;
      cur_d = cur_q;
      modeByte_d = modeByte_q;
      unique case (state_q)
         pfh_pkg::ST_IDLE: begin
            if (take) begin
               cur_d = req;
               modeByte_d = byteMode;
               state_d = req.isWrite ? pfh_pkg::ST_WR_SETUP : pfh_pkg::ST_RD_SETUP;
            end
         end
         pfh_pkg::ST_RD_SETUP: begin
            cnt_d = pfh_pkg::CNT_ZERO;
            state_d = pfh_pkg::ST_RD_WAIT;
         end
         pfh_pkg::ST_RD_WAIT: begin
            if (rdDone) begin
               state_d = pfh_pkg::ST_IDLE;
            end
         end
         pfh_pkg::ST_WR_SETUP: begin
            cnt_d = pfh_pkg::CNT_ZERO;
            state_d = pfh_pkg::ST_WR_PULSE;
         end
         pfh_pkg::ST_WR_PULSE: begin
            if (cnt_q == pfh_pkg::WR_LAST) begin
               state_d = pfh_pkg::ST_WR_HOLD;
            end
         end
         pfh_pkg::ST_WR_HOLD: begin
            state_d = pfh_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered pin values, decoded from the next state

   logic inRd, inWr, gateOn, strobeOn;
   pfh_pkg::pfh_bus_s bus_d;

   assign inRd = (state_d == pfh_pkg::ST_RD_SETUP) || (state_d == pfh_pkg::ST_RD_WAIT);
   assign inWr = (state_d == pfh_pkg::ST_WR_SETUP) || (state_d == pfh_pkg::ST_WR_PULSE) ||
                 (state_d == pfh_pkg::ST_WR_HOLD);
   assign gateOn = (state_d == pfh_pkg::ST_RD_WAIT);
   assign strobeOn = (state_d == pfh_pkg::ST_WR_PULSE);
   // chip select frames the whole cycle; setup and hold keep address steady
   assign bus_d.chipSelN = !(inRd || inWr);
   assign bus_d.outGateN = !gateOn;
   assign bus_d.wrStrobeN = !strobeOn;
   assign bus_d.addrLines = addrSel;

   // the flops that drive the pins and the user answer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= pfh_pkg::ST_IDLE;
         cnt_q <= pfh_pkg::CNT_ZERO;
         cur_q <= '0;
         modeByte_q <= 1'b0;
         bus <= '{chipSelN: 1'b1, outGateN: 1'b1, wrStrobeN: 1'b1, addrLines: '0};
         reqReady <= 1'b0;
         rspValid <= 1'b0;
         rspData <= '0;
         busy <= 1'b0;
         resetUnprotectN <= 1'b0;
         wordSel <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cur_q <= cur_d;
         modeByte_q <= modeByte_d;
         bus <= bus_d;
         reqReady <= (state_d == pfh_pkg::ST_IDLE);
         rspValid <= rdDone || (state_q == pfh_pkg::ST_WR_HOLD);
         rspData <= rdDone ? rdWord : '0;
         busy <= busySync;
         resetUnprotectN <= !flashReset;
         wordSel <= !modeByte_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data lane drivers: driven only while a command write runs, the top pin also throughout byte mode

   // lanes stay released outside writes, except the top pin in byte mode, so a read never meets our drive
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowLaneOut <= '0;
         lowLaneOe <= 1'b0;
         upperLaneOut <= '0;
         upperLaneOe <= 1'b0;
         topDataOut <= 1'b0;
         topDataOe <= 1'b0;
      end else begin
         lowLaneOut <= cur_d.data[pfh_pkg::BYTE_W-1:0];
         lowLaneOe <= inWr;
         upperLaneOut <= cur_d.data[pfh_pkg::DATA_W-2:pfh_pkg::BYTE_W];
         upperLaneOe <= inWr && !modeByte_d;
         // in byte mode the top pin is the byte address and always driven
         topDataOut <= modeByte_d ? cur_d.addr[0] : cur_d.data[pfh_pkg::DATA_W-1];
         topDataOe <= modeByte_d || inWr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_gate_strobe_excl: assert property (
      !(!bus.outGateN && !bus.wrStrobeN))
      else $error("gate and strobe low together");

   chk_lane_no_clash: assert property (
      (lowLaneOe || upperLaneOe) |-> bus.outGateN)
      else $error("host drives lanes while gate is low");

   chk_gate_needs_cs: assert property (
      (!bus.outGateN || !bus.wrStrobeN) |-> !bus.chipSelN)
      else $error("strobe active without chip select");

   chk_strobe_width: assert property (
      $fell(bus.wrStrobeN) |-> (!bus.wrStrobeN)[*2] ##1 bus.wrStrobeN)
      else $error("write strobe width wrong");

   chk_cmd_data_held: assert property (
      !bus.wrStrobeN |-> lowLaneOe && $stable(lowLaneOut) && $past(lowLaneOe))
      else $error("command data not held around strobe");

   chk_cmd_addr_held: assert property (
      (!bus.wrStrobeN || $rose(bus.wrStrobeN)) |-> $stable(bus.addrLines))
      else $error("command address moved during write");

   chk_byte_lanes: assert property (
      (!wordSel && $stable(wordSel)) |-> topDataOe && !upperLaneOe)
      else $error("byte mode lane use wrong");

   chk_read_answer: assert property (
      $fell(bus.outGateN) |-> !rspValid ##4 (rspValid && bus.outGateN))
      else $error("read answer not four cycles after gate");

   chk_status_upper: assert property (
      (rspValid && !wordSel) |-> rspData[15:8] == 8'h00)
      else $error("upper bits not cleared in byte mode");

   cov_word_read: cover property ($fell(bus.outGateN) && wordSel);
   cov_byte_read: cover property ($fell(bus.outGateN) && !wordSel);
   cov_cmd_write: cover property ($rose(bus.wrStrobeN) ##2 rspValid);
   cov_busy_seen: cover property ($rose(busy));

endmodule // pfh_host

`default_nettype wire

// >>> testbench/pfh_flash_model.sv
/*
   behavioural flash part for the host controller bench: small array, one-write
   program command, open-drain ready/busy with its pull-up.
   assumes the bench resolves every lane from the host's enables and otherwise takes the model's output.
*/
`default_nettype none

module pfh_flash_model (
   input wire pfh_pkg::pfh_bus_s bus,
   input wire logic wordSel,
   input wire logic [15:0] dataIn,
   output logic [15:0] dataOut,
   output logic readOe,
   output logic readyBusyN,
   input wire logic resetN
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PROG_CMD = 8'ha0; // arbitrary command code
   // boot cell sits at the top end of the little array and is held protected
   localparam logic [3:0] BOOT_CELL = 4'hf;
   logic [15:0] mem [16];
   logic [15:0] lastQ = 16'h0000;
   logic armed = 1'b0;
   logic busyQ = 1'b0;
   wire [15:0] word = mem[bus.addrLines[3:0]];
   wire [7:0] pick = dataIn[15] ? word[15:8] : word[7:0];
   wire rdLo = !bus.chipSelN && !bus.outGateN;
   wire rdHi = rdLo && wordSel;
   wire locked = (bus.addrLines[3:0] == BOOT_CELL);

   ////////////////////////////////////////////////////////////////////////////
   // read mode from power-up, array shipped erased
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hffff;
      end
   end

   // released lanes show the inverse of the last read, never a stale copy
   always @(posedge bus.outGateN) lastQ <= ~word;
   assign readOe = rdLo;
   assign dataOut[7:0] = rdLo ? (wordSel ? word[7:0] : pick) : lastQ[7:0];
   assign dataOut[15:8] = rdHi ? word[15:8] : lastQ[15:8];
   assign readyBusyN = busyQ ? 1'b0 : 1'b1; // pull-up wins when released

   // hardware reset drops a half-entered command, back to read mode
   always @(negedge resetN) armed <= 1'b0;

   // decoder sees the low lane only; a program touches one cell
   always @(posedge bus.wrStrobeN) begin
      if (!bus.chipSelN && !busyQ) begin
         if (armed) begin
            // a protected cell still runs the algorithm but keeps its contents
            if (!locked) begin
               if (wordSel) mem[bus.addrLines[3:0]] <= word & dataIn;
               else if (dataIn[15]) mem[bus.addrLines[3:0]] <= word & {dataIn[7:0], 8'hff};
               else mem[bus.addrLines[3:0]] <= word & {8'hff, dataIn[7:0]};
            end
            armed <= 1'b0;
            busyQ <= 1'b1;
            busyQ <= #2000 1'b0;
         end else begin
            armed <= (dataIn[7:0] == PROG_CMD);
         end
      end
   end
endmodule // pfh_flash_model

`default_nettype wire

// >>> testbench/tb_top.sv
/*
   self-checking bench for the flash host controller with the flash model.
   assumes a 25 MHz clock and that the host drives lanes only off its read cycles, save the top pin in byte mode.
*/
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic byteMode = 1'b0;
   logic flashReset = 1'b0;
   pfh_pkg::pfh_req_s req = '0;
   pfh_pkg::pfh_bus_s bus;
   logic reqReady, rspValid, busy, wordSel, lowLaneOe, upperLaneOe, topDataOe, topDataOut;
   logic readyBusyN, resetUnprotectN, readOe;
   logic [15:0] rspData, flashOut, pins;
   logic [7:0] lowLaneOut;
   logic [6:0] upperLaneOut;
   int failures = 0;
   int tests_run = 0;

   always #20 clk_sys = ~clk_sys;

   // each lane group carries the host value when the host enables it, else the flash output
   assign pins = {topDataOe ? topDataOut : flashOut[15],
                  upperLaneOe ? upperLaneOut : flashOut[14:8],
                  lowLaneOe ? lowLaneOut : flashOut[7:0]};

   pfh_host i_dut (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
      .req(req), .byteMode(byteMode), .flashReset(flashReset), .rspValid(rspValid),
      .rspData(rspData), .busy(busy), .bus(bus), .wordSel(wordSel),
      .lowLaneIn(pins[7:0]), .lowLaneOut(lowLaneOut), .lowLaneOe(lowLaneOe),
      .upperLaneIn(pins[14:8]), .upperLaneOut(upperLaneOut), .upperLaneOe(upperLaneOe),
      .topDataIn(pins[15]), .topDataOut(topDataOut), .topDataOe(topDataOe),
      .readyBusyN(readyBusyN), .resetUnprotectN(resetUnprotectN));

   pfh_flash_model i_flash (.bus(bus), .wordSel(wordSel), .dataIn(pins),
      .dataOut(flashOut), .readOe(readOe), .readyBusyN(readyBusyN),
      .resetN(resetUnprotectN));

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one request, bounded waits on ready and on the answer
   task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                         output logic [15:0] rd);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 50) begin @(posedge clk_sys); #1; n++; end
      req = '{isWrite: wr, addr: a, data: d};
      reqValid = 1'b1;
      @(posedge clk_sys); #1;
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 20) begin @(posedge clk_sys); #1; n++; end
      check({15'h0000, rspValid}, 16'h0001);
      rd = rspData;
   endtask

   task automatic rd_check(input logic [19:0] a, input logic [15:0] exp);
      logic [15:0] rd;
      access(1'b0, a, 16'h0000, rd);
      check(rd, exp);
   endtask

   // command carries junk in its upper byte on purpose
   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      logic [15:0] rd;
      int n;
      access(1'b1, 20'h00000, 16'h55a0, rd);
      access(1'b1, a, d, rd);
      check(rd, 16'h0000);
      n = 0;
      while (busy !== 1'b1 && n < 10) begin @(posedge clk_sys); #1; n++; end
      check({15'h0000, busy}, 16'h0001);
      n = 0;
      while (busy !== 1'b0 && n < 100) begin @(posedge clk_sys); #1; n++; end
      check({15'h0000, busy}, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({13'h0000, bus.chipSelN, bus.outGateN, bus.wrStrobeN}, 16'h0007);
      check({13'h0000, lowLaneOe, upperLaneOe, topDataOe}, 16'h0000);
      @(posedge clk_sys); #1;
      rst = 1'b0;
      @(posedge clk_sys); #1;
      check({13'h0000, resetUnprotectN, wordSel, busy}, 16'h0006);
   endtask

   task automatic t_erased();
      rd_check(20'h00003, 16'hffff);
      rd_check(20'h0000f, 16'hffff);
   endtask

   task automatic t_word_prog();
      prog(20'h00005, 16'h1234);
      rd_check(20'h00005, 16'h1234);
      rd_check(20'h00003, 16'hffff);
   endtask

   task automatic t_byte_mode();
      byteMode = 1'b1;
      rd_check(20'h0000b, 16'h0012);
      check({15'h0000, wordSel}, 16'h0000);
      rd_check(20'h0000a, 16'h0034);
   endtask

   task automatic t_byte_prog();
      prog(20'h00005, 16'hff00);
      rd_check(20'h00005, 16'h0000);
      byteMode = 1'b0;
      rd_check(20'h00002, 16'h00ff);
   endtask

   task automatic t_protect();
      prog(20'h0000f, 16'h0000);
      rd_check(20'h0000f, 16'hffff);
   endtask

   // a flash reset between command and data must leave the cell alone
   task automatic t_flash_reset();
      logic [15:0] rd;
      access(1'b1, 20'h00000, 16'h00a0, rd);
      flashReset = 1'b1;
      @(posedge clk_sys); #1;
      check({15'h0000, resetUnprotectN}, 16'h0000);
      flashReset = 1'b0;
      @(posedge clk_sys); #1;
      check({15'h0000, resetUnprotectN}, 16'h0001);
      access(1'b1, 20'h00007, 16'h0000, rd);
      rd_check(20'h00007, 16'hffff);
   endtask

   // host low and upper lanes must be released whenever the flash drives them
   always @(negedge clk_sys) begin
      if (!rst && readOe === 1'b1) check({15'h0000, lowLaneOe | upperLaneOe}, 16'h0000);
   end

   initial begin
      #100000;
      failures++;
      conclude();
   end

   initial begin
      @(posedge clk_sys); #1;
      t_reset();
      t_erased();
      t_word_prog();
      t_byte_mode();
      t_byte_prog();
      t_protect();
      t_flash_reset();
      conclude();
   end
endmodule // tb_top

`default_nettype wire
